//--- rtl/slpr_regs.sv
// serial link parameter register bank with apb slave, lane checksum and multiframe counter
`timescale 1ns/1ns
// How it works
// - subclass field 00 runs link in subclass 0, 01 in subclass 1
// - read-only per-sample width field returns bits per sample minus one
// - read-only samples-per-frame field returns count minus one
// - high-density flag is read-only and always reads zero
// - control-words-per-frame field is read-only and reads zero
// - two eight-bit scratch registers hold written values, no link effect
// - lane checksum reads sum of all lane link parameters modulo 256
// - driver power-down bit zero enables drivers, one powers them down
// - sysref loads the multiframe phase counter with the programmed offset
// - preemphasis register 0x04 disables preemphasis, 0x14 enables it
module slpr_regs #(
   parameter int SAMPLE_BITS       = 16,  // total bits per sample on the link
   parameter int SAMPLES_PER_FRAME = 1    // samples per converter per frame
) (
   input  wire logic                       sys_clk_in,       // system clock, 10 MHz
   input  wire logic                       rst_in,           // synchronous reset, high
   input  wire logic                       psel_in,          // apb select
   input  wire logic                       penable_in,       // apb enable
   input  wire logic                       pwrite_in,        // apb direction, high is write
   input  wire logic [11:0]                paddr_in,         // apb byte address
   input  wire logic [31:0]                pwdata_in,        // apb write data
   output logic                            pready_out,       // apb ready
   output logic                            pslverr_out,      // apb error, unmapped address
   output logic [31:0]                     prdata_out,       // apb read data
   input  wire slpr_pkg::slpr_link_params_t link_params_in,  // earlier link bank fields
   input  wire logic                       sysref_in,        // system reference, level
   input  wire logic                       frame_tick_in,    // one frame clock enable pulse
   output logic [1:0]                      subclass_out,     // active link subclass
   output logic                            drivers_on_out,   // serial drivers enabled
   output logic                            preemph_on_out,   // output preemphasis enabled
   output logic [4:0]                      lmfc_phase_out,   // multiframe phase counter
   output logic                            lmfc_edge_out,    // multiframe boundary pulse
   output logic [7:0]                      checksum_out      // current lane checksum
);

   // refuse widths the read-only fields cannot carry
   // checked while the design is built, before any clock runs
   if (SAMPLE_BITS < 1 || SAMPLE_BITS > 16) begin : g_bad_sample_bits
      $error("SAMPLE_BITS must lie in 1..16");
   end
   if (SAMPLES_PER_FRAME < 1 || SAMPLES_PER_FRAME > 32) begin : g_bad_spf
      $error("SAMPLES_PER_FRAME must lie in 1..32");
   end

   // read-only link fields derived from the parameters
   localparam logic [3:0] NPRIME_M1 = 4'(SAMPLE_BITS - 1);
   localparam logic [4:0] SPF_M1    = 5'(SAMPLES_PER_FRAME - 1);

   // bus request carried as one struct
   slpr_pkg::slpr_apb_req_t req;
   slpr_pkg::slpr_apb_rsp_t rsp_reg;

   // stored fields
   logic [1:0] subclass_reg;
   logic       spf_rsvd_reg;
   logic [7:0] scratch_one_reg;
   logic [7:0] scratch_two_reg;
   logic       drv_pd_reg;
   logic [4:0] phase_ofs_reg;
   logic [7:0] preemph_reg;
   logic [7:0] checksum_reg;
   logic [7:0] checksum_next;
   logic [4:0] lmfc_reg;
   logic       lmfc_edge_reg;
   logic       sysref_reg;

   // decode results
   logic       setup_phase;
   logic       write_now;
   logic [9:0] word_idx;
   logic       idx_hit;
   logic [7:0] read_value;
   logic       sysref_rise;
   logic       lmfc_wrap;

   // byte address to register index; low two bits select no register
   function automatic logic [7:0] to_index(input logic [11:0] addr);
      return addr[9:2];
   endfunction

   // true when the index names a register of this bank
   function automatic logic is_mapped(input logic [7:0] idx);
      logic hit;
      hit = 1'b0;
      unique case (idx)
         slpr_pkg::IDX_SUBCLASS_WIDTH,
         slpr_pkg::IDX_SAMPLES_FRAME,
         slpr_pkg::IDX_DENSITY_CTRL,
         slpr_pkg::IDX_SCRATCH_ONE,
         slpr_pkg::IDX_SCRATCH_TWO,
         slpr_pkg::IDX_LANE_CHECKSUM,
         slpr_pkg::IDX_DRIVER_CTRL,
         slpr_pkg::IDX_PHASE_OFFSET,
         slpr_pkg::IDX_PREEMPHASIS: hit = 1'b1;
         default:                   hit = 1'b0;
      endcase
      return hit;
   endfunction

   // eight-bit modular add used across the checksum sum
   function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0];
   endfunction

   // true in the access cycle whose closing edge lands a write on the given register;
   // read-only fields simply have no caller, so writes to them vanish without error
   function automatic logic wr_to(input logic [7:0] idx);
      return write_now && idx_hit && (word_idx[7:0] == idx);
   endfunction

   // gather the bus pins into the request carrier
   assign req.sel    = psel_in;
   assign req.enable = penable_in;
   assign req.write  = pwrite_in;
   assign req.addr   = paddr_in;
   assign req.wdata  = pwdata_in;

   // a register write lands at the edge ending the access phase
   assign setup_phase = req.sel & ~req.enable;
   assign write_now   = req.sel & req.enable & req.write & rsp_reg.ready;
   assign word_idx    = {2'h0, to_index(req.addr)};
   assign idx_hit     = (req.addr[11:10] == 2'h0) & (req.addr[1:0] == 2'h0)
                        & is_mapped(word_idx[7:0]);

   // read mux, open bits read zero; the samples-per-frame reserved bit reads back as stored
   always_comb begin
      read_value = 8'h00;
      unique case (word_idx[7:0])
         slpr_pkg::IDX_SUBCLASS_WIDTH: begin
            read_value[slpr_pkg::SUBCLASS_LSB +: 2] = subclass_reg;
            read_value[3:0]                         = NPRIME_M1;
         end
         slpr_pkg::IDX_SAMPLES_FRAME: begin
            read_value[slpr_pkg::SPF_RSVD_BIT] = spf_rsvd_reg;
            read_value[4:0]                    = SPF_M1;
         end
         slpr_pkg::IDX_DENSITY_CTRL: begin
            read_value[slpr_pkg::HD_BIT] = slpr_pkg::HD_VALUE;
            read_value[4:0]              = slpr_pkg::CF_VALUE;
         end
         slpr_pkg::IDX_SCRATCH_ONE:   read_value = scratch_one_reg;
         slpr_pkg::IDX_SCRATCH_TWO:   read_value = scratch_two_reg;
         slpr_pkg::IDX_LANE_CHECKSUM: read_value = checksum_reg;
         slpr_pkg::IDX_DRIVER_CTRL: begin
            read_value[slpr_pkg::DRV_PD_BIT] = drv_pd_reg;
         end
         slpr_pkg::IDX_PHASE_OFFSET: begin
            read_value[4:0] = phase_ofs_reg;
         end
         slpr_pkg::IDX_PREEMPHASIS: begin
            read_value = preemph_reg;
         end
         default:                     read_value = 8'h00;
      endcase
   end

   // answer prepared in setup so that ready, data and error stand in the access cycle
   // zero wait states: ready rises one cycle after setup, whatever the address
   // a refused transfer still completes, only the error flag tells the master
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rsp_reg <= '0;
      end else if (setup_phase) begin
         rsp_reg.ready  <= 1'b1;
         rsp_reg.slverr <= ~idx_hit;
         rsp_reg.rdata  <= (idx_hit & ~req.write) ? {24'h000000, read_value} : 32'h00000000;
      end else begin
         rsp_reg <= '0;
      end
   end

   // subclass field, the only writable part of its register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         subclass_reg <= slpr_pkg::RST_SUBCLASS;
      end else if (wr_to(slpr_pkg::IDX_SUBCLASS_WIDTH)) begin
         subclass_reg <= req.wdata[slpr_pkg::SUBCLASS_LSB +: 2];
      end
   end

   // reserved bit of samples-per-frame kept as written; software holds it at one
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         spf_rsvd_reg <= slpr_pkg::RST_SPF_RSVD;
      end else if (wr_to(slpr_pkg::IDX_SAMPLES_FRAME)) begin
         spf_rsvd_reg <= req.wdata[slpr_pkg::SPF_RSVD_BIT];
      end
   end

   // first scratch register for software use, wired to nothing else
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         scratch_one_reg <= slpr_pkg::RST_SCRATCH;
      end else if (wr_to(slpr_pkg::IDX_SCRATCH_ONE)) begin
         scratch_one_reg <= req.wdata[7:0];
      end
   end

   // second scratch register, same behaviour
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         scratch_two_reg <= slpr_pkg::RST_SCRATCH;
      end else if (wr_to(slpr_pkg::IDX_SCRATCH_TWO)) begin
         scratch_two_reg <= req.wdata[7:0];
      end
   end

   // driver power-down bit
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         drv_pd_reg <= slpr_pkg::RST_DRV_PD;
      end else if (wr_to(slpr_pkg::IDX_DRIVER_CTRL)) begin
         drv_pd_reg <= req.wdata[slpr_pkg::DRV_PD_BIT];
      end
   end

   // multiframe phase offset
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         phase_ofs_reg <= slpr_pkg::RST_PHASE_OFS;
      end else if (wr_to(slpr_pkg::IDX_PHASE_OFFSET)) begin
         phase_ofs_reg <= req.wdata[4:0];
      end
   end

   // preemphasis selection byte
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         preemph_reg <= slpr_pkg::RST_PREEMPH;
      end else if (wr_to(slpr_pkg::IDX_PREEMPHASIS)) begin
         preemph_reg <= req.wdata[7:0];
      end
   end

   // sum of every lane link parameter, ours and the earlier bank's
   always_comb begin
      checksum_next = 8'h00;
      checksum_next = add8(checksum_next, link_params_in.device_id);
      checksum_next = add8(checksum_next, {4'h0, link_params_in.bank_id});
      checksum_next = add8(checksum_next, {3'h0, link_params_in.lane_id});
      checksum_next = add8(checksum_next, {7'h00, link_params_in.scramble});
      checksum_next = add8(checksum_next, {3'h0, link_params_in.lanes_m1});
      checksum_next = add8(checksum_next, link_params_in.octets_m1);
      checksum_next = add8(checksum_next, {3'h0, link_params_in.frames_m1});
      checksum_next = add8(checksum_next, link_params_in.converters_m1);
      checksum_next = add8(checksum_next, {6'h00, link_params_in.ctrl_bits});
      checksum_next = add8(checksum_next, {4'h0, link_params_in.resolution_m1});
      checksum_next = add8(checksum_next, {6'h00, subclass_reg});
      checksum_next = add8(checksum_next, {4'h0, NPRIME_M1});
      checksum_next = add8(checksum_next, {3'h0, SPF_M1});
      checksum_next = add8(checksum_next, {7'h00, slpr_pkg::HD_VALUE});
      checksum_next = add8(checksum_next, {3'h0, slpr_pkg::CF_VALUE});
   end

   // checksum refreshed every cycle so it follows any parameter change
   // a read sees a change one clock after it, well inside any transfer
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         checksum_reg <= 8'h00;
      end else begin
         checksum_reg <= checksum_next;
      end
   end

   // sysref edge detect, the input is already synchronous
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sysref_reg <= 1'b0;
      end else begin
         sysref_reg <= sysref_in;
      end
   end

   // sysref rising edge and the last frame of the multiframe
   assign sysref_rise = sysref_in & ~sysref_reg;
   assign lmfc_wrap   = (lmfc_reg == link_params_in.frames_m1);

   // multiframe phase counter: sysref rising edge loads the offset, ahead of a frame tick
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         lmfc_reg <= slpr_pkg::RST_PHASE_OFS;
      end else if (sysref_rise) begin
         lmfc_reg <= phase_ofs_reg;
      end else if (frame_tick_in) begin
         lmfc_reg <= lmfc_wrap ? 5'h00 : lmfc_reg + 5'h01;
      end
   end

   // boundary pulse for one cycle when a tick wraps the counter; a reload never flags one
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         lmfc_edge_reg <= 1'b0;
      end else begin
         lmfc_edge_reg <= frame_tick_in & lmfc_wrap & ~sysref_rise;
      end
   end

   // active subclass to the link, one cycle behind its field
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         subclass_out <= slpr_pkg::RST_SUBCLASS;
      end else begin
         subclass_out <= subclass_reg;
      end
   end

   // serial drivers run unless powered down; held off while in reset
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         drivers_on_out <= 1'b0;
      end else begin
         drivers_on_out <= ~drv_pd_reg;
      end
   end

   // preemphasis only for its enable code, every other code leaves it off
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         preemph_on_out <= 1'b0;
      end else begin
         preemph_on_out <= (preemph_reg == slpr_pkg::PREEMPH_ON);
      end
   end

   // bus answer and status straight from flip-flops
   assign pready_out     = rsp_reg.ready;
   assign pslverr_out    = rsp_reg.slverr;
   assign prdata_out     = rsp_reg.rdata;
   assign lmfc_phase_out = lmfc_reg;
   assign lmfc_edge_out  = lmfc_edge_reg;
   assign checksum_out   = checksum_reg;

endmodule // slpr_regs

//--- rtl/slpr_pkg.sv
// package for the serial link parameter register bank: offsets, fields, resets, carriers
package slpr_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_SUBCLASS_WIDTH  = 8'h73;
   localparam logic [7:0] IDX_SAMPLES_FRAME   = 8'h74;
   localparam logic [7:0] IDX_DENSITY_CTRL    = 8'h75;
   localparam logic [7:0] IDX_SCRATCH_ONE     = 8'h76;
   localparam logic [7:0] IDX_SCRATCH_TWO     = 8'h77;
   localparam logic [7:0] IDX_LANE_CHECKSUM   = 8'h79;
   localparam logic [7:0] IDX_DRIVER_CTRL     = 8'h80;
   localparam logic [7:0] IDX_PHASE_OFFSET    = 8'h8B;
   localparam logic [7:0] IDX_PREEMPHASIS     = 8'hA8;

   // field positions
   localparam int SUBCLASS_LSB    = 5;
   localparam int SPF_RSVD_BIT    = 5;
   localparam int HD_BIT          = 7;
   localparam int DRV_PD_BIT      = 1;

   // subclass codes
   localparam logic [1:0] SUBCLASS_0 = 2'h0;
   localparam logic [1:0] SUBCLASS_1 = 2'h1;

   // preemphasis codes
   localparam logic [7:0] PREEMPH_OFF = 8'h04;
   localparam logic [7:0] PREEMPH_ON  = 8'h14;

   // values after reset
   localparam logic [1:0] RST_SUBCLASS   = 2'h0;
   localparam logic       RST_SPF_RSVD   = 1'h1;
   localparam logic [7:0] RST_SCRATCH    = 8'h00;
   localparam logic       RST_DRV_PD     = 1'h0;
   localparam logic [4:0] RST_PHASE_OFS  = 5'h00;
   localparam logic [7:0] RST_PREEMPH    = 8'h04;
   localparam logic [4:0] RST_LMFC_LAST  = 5'h1F;

   // constant read-only link fields
   localparam logic       HD_VALUE       = 1'h0;
   localparam logic [4:0] CF_VALUE       = 5'h00;

   // one apb request as the master presents it
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } slpr_apb_req_t;

   // one apb answer from this slave
   typedef struct packed {
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } slpr_apb_rsp_t;

   // link parameters held by the earlier link control bank, fed in for the checksum
   typedef struct packed {
      logic [7:0] device_id;
      logic [3:0] bank_id;
      logic [4:0] lane_id;
      logic       scramble;
      logic [4:0] lanes_m1;
      logic [7:0] octets_m1;
      logic [4:0] frames_m1;
      logic [7:0] converters_m1;
      logic [1:0] ctrl_bits;
      logic [3:0] resolution_m1;
   } slpr_link_params_t;

endpackage

//--- test/slpr_regs_asserts.sv
// checker for the serial link parameter register bank, bound to its top module
`timescale 1ns/1ns
module slpr_regs_chk #(
   parameter int SAMPLE_BITS = 16  // bits per sample
) (
   input wire logic        sys_clk_in,     // clock
   input wire logic        rst_in,         // reset
   input wire logic        psel_in,        // select
   input wire logic        penable_in,     // enable
   input wire logic        pwrite_in,      // direction
   input wire logic [11:0] paddr_in,       // address
   input wire logic [31:0] pwdata_in,      // write data
   input wire logic        pready_out,     // ready
   input wire logic        pslverr_out,    // error
   input wire logic [31:0] prdata_out,     // read data
   input wire logic        sysref_in,      // reference
   input wire logic [1:0]  subclass_out,   // subclass
   input wire logic        drivers_on_out, // drivers on
   input wire logic        preemph_on_out, // preemphasis
   input wire logic [4:0]  lmfc_phase_out, // phase
   input wire logic [7:0]  checksum_out    // checksum
);
   logic       wr;
   logic       rd;
   logic [4:0] ofs_reg;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // completed writes and reads
   assign wr = pready_out && pwrite_in;
   assign rd = pready_out && !pwrite_in;
   // shadow of the phase offset as written over the bus
   always_ff @(posedge sys_clk_in) begin
      if (rst_in)
         ofs_reg <= 5'h00;
      else if (wr && paddr_in == 12'h22C)
         ofs_reg <= pwdata_in[4:0];
   end
   a_zero_wait: assert property (psel_in && !penable_in |=> pready_out)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   a_subclass_wr: assert property (wr && paddr_in == 12'h1CC |->
      ##2 subclass_out == $past(pwdata_in[6:5], 2)) else $error("subclass wrong");
   a_width_ro: assert property (rd && paddr_in == 12'h1CC |->
      prdata_out[3:0] == 4'(SAMPLE_BITS - 1)) else $error("sample width wrong");
   a_spf_ro: assert property (rd && paddr_in == 12'h1D0 |->
      prdata_out[4:0] == 5'h00) else $error("samples per frame wrong");
   a_density_zero: assert property (rd && paddr_in == 12'h1D4 |->
      prdata_out == 32'h0) else $error("density register not zero");
   a_checksum_rd: assert property (rd && paddr_in == 12'h1E4 |->
      prdata_out[7:0] == $past(checksum_out)) else $error("checksum read wrong");
   a_driver_pd: assert property (wr && paddr_in == 12'h200 |->
      ##2 drivers_on_out == !$past(pwdata_in[1], 2)) else $error("driver state wrong");
   a_sysref_load: assert property ($rose(sysref_in) |->
      ##1 lmfc_phase_out == $past(ofs_reg)) else $error("phase not loaded");
   a_preemph_code: assert property (wr && paddr_in == 12'h2A0 |->
      ##2 preemph_on_out == ($past(pwdata_in[7:0], 2) == 8'h14)) else $error("preemph wrong");
   a_unmapped_err: assert property (pready_out && paddr_in == 12'h1E0 |->
      pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
   c_drv_write: cover property (wr && paddr_in == 12'h200);
   c_sysref: cover property ($rose(sysref_in));
   c_refused: cover property (pready_out && pslverr_out);
endmodule // slpr_regs_chk

bind slpr_regs slpr_regs_chk #(.SAMPLE_BITS(SAMPLE_BITS)) chk (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
   .sysref_in(sysref_in), .subclass_out(subclass_out), .drivers_on_out(drivers_on_out),
   .preemph_on_out(preemph_on_out), .lmfc_phase_out(lmfc_phase_out),
   .checksum_out(checksum_out));

//--- test/slpr_host.sv
// apb host model that configures the register bank
`timescale 1ns/1ns
module slpr_host (
   input  wire logic        sys_clk_in,  // clock
   input  wire logic        pready_in,   // ready
   input  wire logic        pslverr_in,  // error
   input  wire logic [31:0] prdata_in,   // read data
   output logic             psel_out,    // select
   output logic             penable_out, // enable
   output logic             pwrite_out,  // direction
   output logic [11:0]      paddr_out,   // address
   output logic [31:0]      pwdata_out   // write data
);
   // bus idle at time zero
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 12'h000;
      pwdata_out = 32'h0;
   end
   // one transfer: setup, access held until ready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic ok);
      int i;
      ok = 1'b0;
      @(posedge sys_clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= (a == 12'h1D0) ? (d | 32'h20) : d;
      @(posedge sys_clk_in);
      penable_out <= 1'b1;
      for (i = 0; i < 16 && !ok; i++) begin
         @(posedge sys_clk_in);
         ok = pready_in;
      end
      rd = prdata_in;
      err = pslverr_in;
      // released lines flip so stale values never pass; bus idles between calls
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      paddr_out <= ~a;
      pwdata_out <= ~pwdata_out;
   endtask
endmodule // slpr_host

//--- test/slpr_regs_tb.sv
// self-checking testbench for the serial link parameter register bank
`timescale 1ns/1ns
module slpr_regs_tb;
   logic                        sys_clk_in, rst_in, psel, penable, pwrite;
   logic [11:0]                 paddr;
   logic [31:0]                 pwdata, prdata, rd;
   logic                        pready, pslverr, err, ok, sysref_in, frame_tick_in;
   logic                        drv_on, pe_on, lmfc_edge;
   logic [1:0]                  subclass;
   logic [4:0]                  phase;
   slpr_pkg::slpr_link_params_t lp;
   int                          num_errors, n_checks;
   logic [19:0]                 rst_tab [8];
   logic [7:0]                  pe [3];
   slpr_regs dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .link_params_in(lp),
      .sysref_in(sysref_in), .frame_tick_in(frame_tick_in), .subclass_out(subclass),
      .drivers_on_out(drv_on), .preemph_on_out(pe_on), .lmfc_phase_out(phase),
      .lmfc_edge_out(lmfc_edge), .checksum_out());
   slpr_host host (.sys_clk_in(sys_clk_in), .pready_in(pready), .pslverr_in(pslverr),
      .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata));
   // clock
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one bus transfer with its expected read data and error flag
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input logic eerr);
      host.xfer(w, a, {24'h0, d}, rd, err, ok);
      check(rd, {24'h0, exp});
      check(32'(err), 32'(eerr));
      if (!ok) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   function automatic logic [7:0] csum(input logic [1:0] sc);
      csum = lp.device_id + lp.bank_id + lp.lane_id + lp.scramble + lp.lanes_m1
         + lp.octets_m1 + lp.frames_m1 + lp.converters_m1 + lp.ctrl_bits
         + lp.resolution_m1 + sc + 8'h0F;
   endfunction
   // main sequence
   initial begin
      rst_in = 1'b1;
      sysref_in = 1'b0;
      frame_tick_in = 1'b0;
      num_errors = 0;
      n_checks = 0;
      lp = '{8'hC3, 4'h9, 5'h11, 1'b1, 5'h00, 8'h01, 5'h07, 8'h00, 2'h2, 4'hA};
      rst_tab = '{20'h1CC0F, 20'h1D020, 20'h1D400, 20'h1D800, 20'h1DC00, 20'h20000,
                  20'h22C00, 20'h2A004};
      pe = '{8'h14, 8'h15, 8'h04};
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      foreach (rst_tab[i]) acc(0, rst_tab[i][19:8], 0, rst_tab[i][7:0], 0);
      check(32'(drv_on), 32'h1);
      acc(1, 12'h1D4, 8'hFF, 0, 0);
      acc(0, 12'h1D4, 0, 8'h00, 0);
      acc(1, 12'h1CC, 8'h3F, 0, 0);
      acc(0, 12'h1CC, 0, 8'h2F, 0);
      check(32'(subclass), 32'h1);
      acc(1, 12'h1D0, 8'h1F, 0, 0);
      acc(0, 12'h1D0, 0, 8'h20, 0);
      acc(0, 12'h1E4, 0, csum(2'h1), 0);
      // the earlier bank changes a lane parameter while the drivers stay on; the checksum read below must follow it
      lp.octets_m1 <= 8'h7F;
      acc(1, 12'h1CC, 8'h00, 0, 0);
      repeat (2) @(posedge sys_clk_in);
      check(32'(subclass), 32'h0);
      acc(0, 12'h1E4, 0, csum(2'h0), 0);
      acc(1, 12'h1D8, 8'hA5, 0, 0);
      acc(1, 12'h1DC, 8'h5A, 0, 0);
      acc(0, 12'h1D8, 0, 8'hA5, 0);
      acc(0, 12'h1DC, 0, 8'h5A, 0);
      // refused: unmapped, misaligned and out-of-range addresses
      acc(0, 12'h1E0, 0, 0, 1);
      acc(1, 12'h1E0, 8'hFF, 0, 1);
      acc(0, 12'h1D9, 0, 0, 1);
      acc(1, 12'hDD8, 8'hEE, 0, 1);
      acc(0, 12'h1D8, 0, 8'hA5, 0);
      for (int i = 1; i >= 0; i--) begin
         acc(1, 12'h200, {6'h0, 1'(i), 1'b0}, 0, 0);
         repeat (2) @(posedge sys_clk_in);
         check(32'(drv_on), 32'(i == 0));
      end
      foreach (pe[i]) begin
         acc(1, 12'h2A0, pe[i], 0, 0);
         repeat (2) @(posedge sys_clk_in);
         check(32'(pe_on), 32'(pe[i] == 8'h14));
      end
      // sysref loads the offset, one tick at the last phase wraps to zero
      acc(1, 12'h22C, 8'hE7, 0, 0);
      sysref_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      check(32'(phase), 32'h07);
      frame_tick_in <= 1'b1;
      @(posedge sys_clk_in);
      frame_tick_in <= 1'b0;
      sysref_in <= 1'b0;
      @(negedge sys_clk_in);
      check(32'(phase), 32'h00);
      check(32'(lmfc_edge), 32'h1);
      @(negedge sys_clk_in);
      check(32'(lmfc_edge), 32'h0);
      // one more tick advances the counter without a boundary pulse
      @(posedge sys_clk_in);
      frame_tick_in <= 1'b1;
      @(posedge sys_clk_in);
      frame_tick_in <= 1'b0;
      @(negedge sys_clk_in);
      check(32'(phase), 32'h01);
      check(32'(lmfc_edge), 32'h0);
      tally_and_finish();
   end
endmodule // slpr_regs_tb
